// ===== hw/spi_control_status_bank_upper.sv
// Serial control register 0 upper fields and status register 0 of the driver
//
// Functional notes
// - Enable bit zero gives standby, one active.
// - Reset bit clears the fault and warning flags at frame end, not the not-ready flag.
// - Overcurrent retry pulses with duty from bit 21.
// - Status bit 23 always reads one.
// - Supply over/undervoltage sets flag in active mode, outputs off.
// - Supply recovery automatic unless bit 20 set.
// - Thermal shutdown sets bit 20 in active mode, outputs off.
// - Temperature warning sticks until master clears it.
// - Standby to active sets not-ready, starts timer.
// - Not-ready clears itself when timer expires.
// - Monitor select routes one of four outputs.
`timescale 1ns/1ps

module spi_control_status_bank_upper #(
   parameter int RETRY_PERIOD = door_drv_pkg::RETRY_PERIOD_CYC,
   parameter int STARTUP = door_drv_pkg::STARTUP_CYC
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Serial pins
   input wire door_drv_pkg::spi_pins_s spi_pins,
   output logic serial_out,
   output logic serial_out_en,
   // Analog fault levels and overcurrent retry request
   input wire door_drv_pkg::fault_in_s fault_in,
   input wire logic overcurrent,
   input wire logic retry_enable,
   // Device state
   output logic active_mode,
   output logic outputs_allowed,
   output logic retry_on,
   output door_drv_pkg::mon_route_s mon_route
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sclk_sync;            // Pin synchronisers, [0] first
      logic [2:0] sel_sync;
      logic [2:0] din_sync;
      logic sclk_f;                     // Filtered pin levels
      logic sel_f;
      door_drv_pkg::link_e link;
      logic [23:0] in_sr;               // Incoming bits, LSB first
      logic [23:0] out_sr;              // Outgoing status bits
      logic [4:0] bit_cnt;              // Rising edges in this frame
      logic enable;
      logic duty_high;
      logic rec_dis;
      logic [1:0] mon_sel;
      logic over_flag;
      logic under_flag;
      logic thermal_shutdown_flag;
      logic temperature_warning_flag;
      logic nrdy_flag;
      logic [31:0] start_cnt;           // Charge pump settle timer
      logic [31:0] retry_cnt;           // Retry period counter
      logic dout;
      logic dout_en;
      logic allowed;
      logic retry;
      door_drv_pkg::mon_route_s route;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // ----------------------------------------------------------------
   // Monitor select decode
   // ----------------------------------------------------------------
   function automatic door_drv_pkg::mon_route_s route_of(input logic [1:0] sel);
      door_drv_pkg::mon_route_s r;
      r = '0;
      unique case (sel)
         door_drv_pkg::MON_HS6: r.high_side_six = 1'b1;
         door_drv_pkg::MON_B1: r.bridge_one_output = 1'b1;
         door_drv_pkg::MON_HS4: r.high_side_four = 1'b1;
         door_drv_pkg::MON_HS5: r.high_side_five = 1'b1;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Status word as read back; lower driver bits live elsewhere
   // ----------------------------------------------------------------
   logic [23:0] status_word;

   always_comb
   begin
      status_word = '0;
      status_word[door_drv_pkg::ST_ALWAYS1] = 1'b1;
      status_word[door_drv_pkg::ST_OVER] = st_r.over_flag;
      status_word[door_drv_pkg::ST_UNDER] = st_r.under_flag;
      status_word[door_drv_pkg::ST_THERMAL] = st_r.thermal_shutdown_flag;
      status_word[door_drv_pkg::ST_WARN] = st_r.temperature_warning_flag;
      status_word[door_drv_pkg::ST_NRDY] = st_r.nrdy_flag;
      // No-error bit is the NOR of bits 1 to 22
      status_word[door_drv_pkg::ST_NOERR] = ~(|status_word[22:1]);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic sclk_rise;
      logic sclk_fall;
      logic sel_fall;
      logic sel_rise;
      logic good_frame;
      logic clear_all;
      logic supply_block;
      logic [31:0] on_cyc;
      // An edge is the agreeing stages leaving the filtered level
      sclk_rise = st_r.sclk_sync[1] & st_r.sclk_sync[2] & ~st_r.sclk_f;
      sclk_fall = ~st_r.sclk_sync[1] & ~st_r.sclk_sync[2] & st_r.sclk_f;
      sel_fall = ~st_r.sel_sync[1] & ~st_r.sel_sync[2] & st_r.sel_f;
      sel_rise = st_r.sel_sync[1] & st_r.sel_sync[2] & ~st_r.sel_f;
      good_frame = 1'b0;
      clear_all = 1'b0;
      supply_block = 1'b0;
      // Retry on-time follows the duty select
      on_cyc = st_r.duty_high ? 32'((RETRY_PERIOD * door_drv_pkg::DUTY_HIGH_PCT) / 100) :
                                32'((RETRY_PERIOD * door_drv_pkg::DUTY_LOW_PCT) / 100);
      st_nxt = st_r;

      // Three-stage pin synchronisers
      st_nxt.sclk_sync = {st_r.sclk_sync[1:0], spi_pins.sclk};
      st_nxt.sel_sync = {st_r.sel_sync[1:0], spi_pins.chip_select_low};
      st_nxt.din_sync = {st_r.din_sync[1:0], spi_pins.serial_in};

      // A level counts once the second and third stages agree
      if (st_r.sclk_sync[1] == st_r.sclk_sync[2])
         st_nxt.sclk_f = st_r.sclk_sync[2];
      if (st_r.sel_sync[1] == st_r.sel_sync[2])
         st_nxt.sel_f = st_r.sel_sync[2];

      // Frame handling
      unique case (st_r.link)
         door_drv_pkg::LINK_IDLE:
         begin
            st_nxt.dout_en = 1'b0;
            if (sel_fall)
            begin
               // Before any clock the pin shows the no-error bit
               st_nxt.link = door_drv_pkg::LINK_FRAME;
               st_nxt.bit_cnt = '0;
               st_nxt.dout_en = 1'b1;
               st_nxt.dout = status_word[door_drv_pkg::ST_NOERR];
            end
         end
         door_drv_pkg::LINK_FRAME:
         begin
            if (sel_rise)
            begin
               st_nxt.link = door_drv_pkg::LINK_IDLE;
               st_nxt.dout_en = 1'b0;
               good_frame = (st_r.bit_cnt == door_drv_pkg::FRAME_BITS_C) &&
                            !st_r.in_sr[door_drv_pkg::SEL_BIT];
            end
            else
            begin
               if (sclk_rise)
               begin
                  st_nxt.in_sr = {st_r.din_sync[2], st_r.in_sr[23:1]};
                  if (st_r.bit_cnt != door_drv_pkg::COUNT_MAX)
                     st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
                  // First rising edge captures the status snapshot
                  if (st_r.bit_cnt == '0)
                     st_nxt.out_sr = {1'b0, status_word[23:1]};
               end
               if (sclk_fall)
               begin
                  st_nxt.dout = st_r.out_sr[0];
                  st_nxt.out_sr = {1'b0, st_r.out_sr[23:1]};
               end
            end
         end
         default:
            st_nxt.link = door_drv_pkg::LINK_IDLE;
      endcase

      // Register write only for a frame of exactly 24 bits
      if (good_frame)
      begin
         st_nxt.enable = st_r.in_sr[door_drv_pkg::CTL_ENABLE];
         st_nxt.duty_high = st_r.in_sr[door_drv_pkg::CTL_DUTY];
         st_nxt.rec_dis = st_r.in_sr[door_drv_pkg::CTL_REC_DIS];
         st_nxt.mon_sel = st_r.in_sr[door_drv_pkg::CTL_MON_HI:door_drv_pkg::CTL_MON_LO];
         clear_all = st_r.in_sr[door_drv_pkg::CTL_RESET];
         // Entering standby also wipes the status
         if (!st_r.in_sr[door_drv_pkg::CTL_ENABLE])
            clear_all = 1'b1;
         if (st_r.in_sr[door_drv_pkg::CTL_ENABLE] && !st_r.enable)
         begin
            st_nxt.nrdy_flag = 1'b1;
            st_nxt.start_cnt = 32'(STARTUP);
         end
      end

      // Clearing first so that a simultaneous event still sets its flag
      if (clear_all)
      begin
         st_nxt.over_flag = 1'b0;
         st_nxt.under_flag = 1'b0;
         st_nxt.thermal_shutdown_flag = 1'b0;
         st_nxt.temperature_warning_flag = 1'b0;
      end
      // Faults are only reported in active mode
      if (st_nxt.enable)
      begin
         if (fault_in.over_voltage)
            st_nxt.over_flag = 1'b1;
         if (fault_in.under_voltage)
            st_nxt.under_flag = 1'b1;
         if (fault_in.thermal_shutdown)
            st_nxt.thermal_shutdown_flag = 1'b1;
         if (fault_in.temp_warning)
            st_nxt.temperature_warning_flag = 1'b1;
      end

      // Start-up timer; standby drops the flag with the rest of the status
      if (!st_nxt.enable)
      begin
         st_nxt.nrdy_flag = 1'b0;
         st_nxt.start_cnt = '0;
      end
      else if (st_r.nrdy_flag && !(good_frame && !st_r.enable))
      begin
         if (st_r.start_cnt <= 32'h0000_0001)
         begin
            st_nxt.nrdy_flag = 1'b0;
            st_nxt.start_cnt = '0;
         end
         else
            st_nxt.start_cnt = st_r.start_cnt - 32'h0000_0001;
      end

      // Supply faults block while present, and latch when recovery is disabled
      supply_block = fault_in.over_voltage | fault_in.under_voltage;
      if (st_r.rec_dis && (st_r.over_flag || st_r.under_flag))
         supply_block = 1'b1;
      st_nxt.allowed = st_r.enable & ~st_r.nrdy_flag & ~st_r.thermal_shutdown_flag &
                       ~fault_in.thermal_shutdown & ~supply_block;

      // Retry pulse train while the driver is overloaded
      if (overcurrent && retry_enable && st_r.allowed)
      begin
         if (st_r.retry_cnt >= 32'(RETRY_PERIOD - 1))
            st_nxt.retry_cnt = '0;
         else
            st_nxt.retry_cnt = st_r.retry_cnt + 32'h0000_0001;
         st_nxt.retry = (st_r.retry_cnt < on_cyc);
      end
      else
      begin
         st_nxt.retry_cnt = '0;
         st_nxt.retry = 1'b0;
      end

      st_nxt.route = route_of(st_r.mon_sel);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         // Power-on leaves the device in standby with chip select idle high
         st_r <= '0;
         st_r.sel_sync <= 3'h7;
         st_r.sel_f <= 1'b1;
         st_r.link <= door_drv_pkg::LINK_IDLE;
         st_r.mon_sel <= door_drv_pkg::MON_RESET;
      end
      else
         st_r <= st_nxt;
   end

   // Outputs straight from the state register
   assign serial_out = st_r.dout;
   assign serial_out_en = st_r.dout_en;
   assign active_mode = st_r.enable;
   assign outputs_allowed = st_r.allowed;
   assign retry_on = st_r.retry;
   assign mon_route = st_r.route;

endmodule

// ===== hw/door_drv_pkg.sv
// Shared constants and carrier types of the serial control and status bank
package door_drv_pkg;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 24;            // Bits in one valid frame
   localparam logic [4:0] FRAME_BITS_C = 5'h18;
   localparam logic [4:0] COUNT_MAX = 5'h1F;  // Counter saturates here
   localparam int SEL_BIT = 0;                // Picks register 0 or 1

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTL_ENABLE = 23;            // Active when one
   localparam int CTL_RESET = 22;             // Clears fault and warning flags at frame end
   localparam int CTL_DUTY = 21;              // Retry duty select
   localparam int CTL_REC_DIS = 20;           // Supply recovery disable
   localparam int CTL_MON_HI = 19;            // Monitor select, high bit
   localparam int CTL_MON_LO = 18;            // Monitor select, low bit

   // ----------------------------------------------------------------
   // Status register field positions
   // ----------------------------------------------------------------
   localparam int ST_ALWAYS1 = 23;
   localparam int ST_OVER = 22;
   localparam int ST_UNDER = 21;
   localparam int ST_THERMAL = 20;
   localparam int ST_WARN = 19;
   localparam int ST_NRDY = 18;
   localparam int ST_NOERR = 0;

   // ----------------------------------------------------------------
   // Reset values and monitor codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MON_RESET = 2'h0;
   localparam logic [1:0] MON_HS6 = 2'h0;     // {bit19,bit18} = 00
   localparam logic [1:0] MON_B1 = 2'h2;      // 10
   localparam logic [1:0] MON_HS4 = 2'h1;     // 01
   localparam logic [1:0] MON_HS5 = 2'h3;     // 11

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;        // ref_clk rate
   localparam int RETRY_FREQ_HZ = 1500;       // Retry pulse rate
   localparam int RETRY_PERIOD_CYC = CLK_HZ / RETRY_FREQ_HZ;
   localparam int DUTY_LOW_PCT = 12;          // Duty with select zero
   localparam int DUTY_HIGH_PCT = 25;         // Duty with select one
   localparam int STARTUP_TIME_US = 100;      // Charge pump settle time
   localparam int STARTUP_CYC = (STARTUP_TIME_US * (CLK_HZ / 1_000_000));

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b01,
      LINK_FRAME = 2'b10
   } link_e;

   // Fault levels reported by the analog monitors
   typedef struct packed {
      logic over_voltage;
      logic under_voltage;
      logic thermal_shutdown;
      logic temp_warning;
   } fault_in_s;

   // Serial pins as seen by the device
   typedef struct packed {
      logic sclk;
      logic chip_select_low;
      logic serial_in;
   } spi_pins_s;

   // Current monitor routing, one-hot
   typedef struct packed {
      logic high_side_six;
      logic bridge_one_output;
      logic high_side_four;
      logic high_side_five;
   } mon_route_s;

endpackage

// ===== bench/spi_bank_props.sv
// Port assertions for the serial control and status bank
`timescale 1ns/1ps
module spi_bank_props #(
   parameter int STARTUP = 8
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Pins and analog inputs
   input wire door_drv_pkg::spi_pins_s spi_pins,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire door_drv_pkg::fault_in_s fault_in,
   input wire logic overcurrent,
   input wire logic retry_enable,
   // Device state
   input wire logic active_mode,
   input wire logic outputs_allowed,
   input wire logic retry_on,
   input wire door_drv_pkg::mon_route_s mon_route
);
   // ------------------------------------
   // Cycles spent active, saturating
   // ------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [15:0] up_cnt_r; // Restarts on every standby
   always_ff @(posedge ref_clk)
   begin
      if (reset || !active_mode)
         up_cnt_r <= 16'h0000;
      else if (up_cnt_r != 16'hFFFF)
         up_cnt_r <= up_cnt_r + 16'h0001;
   end
   // ------------------------------------
   // Assertions
   // ------------------------------------
   a_standby_off: assert property (!active_mode && !$past(active_mode) |-> !outputs_allowed)
      else $error("outputs on in standby");
   a_monitor_hot: assert property (active_mode |-> $onehot(mon_route))
      else $error("monitor route not one-hot");
   a_over_off: assert property ($past(fault_in.over_voltage) |-> !outputs_allowed)
      else $error("outputs on in overvoltage");
   a_under_off: assert property ($past(fault_in.under_voltage) |-> !outputs_allowed)
      else $error("outputs on in undervoltage");
   a_thermal_off: assert property ($past(fault_in.thermal_shutdown) |-> !outputs_allowed)
      else $error("outputs on in thermal shutdown");
   a_retry_cause: assert property (retry_on |-> $past(retry_enable))
      else $error("retry without enable");
   // A pulse may only be cut short by withdrawing the enable
   a_retry_width: assert property ($rose(retry_on) && retry_enable |-> (retry_on || !retry_enable) [*8])
      else $error("retry pulse too short");
   a_startup_hold: assert property (outputs_allowed && active_mode |-> up_cnt_r >= STARTUP)
      else $error("outputs before start-up time");
   a_ready_time: assert property (fault_in == 4'h0 && up_cnt_r == STARTUP + 16 |-> outputs_allowed)
      else $error("outputs late after start-up");
endmodule

bind spi_control_status_bank_upper spi_bank_props #(.STARTUP(STARTUP)) u_props (
   .ref_clk(ref_clk), .reset(reset), .spi_pins(spi_pins), .serial_out(serial_out),
   .serial_out_en(serial_out_en), .fault_in(fault_in), .overcurrent(overcurrent),
   .retry_enable(retry_enable), .active_mode(active_mode),
   .outputs_allowed(outputs_allowed), .retry_on(retry_on), .mon_route(mon_route));

// ===== bench/spi_master_model.sv
// Serial master model that frames control words and gathers status bits
`timescale 1ns/1ps
module spi_master_model (
   // Clock
   input wire logic ref_clk,
   // Device pins
   input wire logic serial_out,
   input wire logic serial_out_en,
   output door_drv_pkg::spi_pins_s pins
);
   // Idle: deselected, clock low
   initial pins = 3'b010;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Sends n bits LSB first; 6-cycle phases clear the 4-cycle minimum
   task automatic xfer(input logic [23:0] wr, input int n, output logic [23:0] rd);
      rd = 24'h00_0000;
      pins.chip_select_low <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         pins.serial_in <= wr[i % 24];
         tick(6);
         // Bit i stands on the line before rise i
         if (i < 24)
            rd[i] = serial_out_en ? serial_out : 1'bx;
         pins.sclk <= 1'b1;
         tick(6);
         pins.sclk <= 1'b0;
      end
      tick(6);
      // Released data line shows the inverse of its last bit
      pins.serial_in <= ~pins.serial_in;
      pins.chip_select_low <= 1'b1;
      tick(12);
   endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the serial control and status bank
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------
   // Design signals and bench state
   // ------------------------------------
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   door_drv_pkg::spi_pins_s spi_pins;
   door_drv_pkg::fault_in_s fault_in = 4'h0;
   logic overcurrent = 1'b0;
   logic retry_enable = 1'b0;
   logic serial_out;
   logic serial_out_en;
   logic active_mode;
   logic outputs_allowed;
   logic retry_on;
   door_drv_pkg::mon_route_s mon_route;
   logic [3:0] mon_exp [4] = '{4'h8, 4'h2, 4'h4, 4'h1}; // Route per select code
   logic [23:0] ctl = 24'h80_0000; // Control word in force
   logic [23:0] rd; // Status word last read
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   // Start-up spans two frames so that a read can catch the not-ready flag
   spi_control_status_bank_upper #(.RETRY_PERIOD(100), .STARTUP(400)) dut (
      .ref_clk(ref_clk), .reset(reset), .spi_pins(spi_pins), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .fault_in(fault_in), .overcurrent(overcurrent),
      .retry_enable(retry_enable), .active_mode(active_mode),
      .outputs_allowed(outputs_allowed), .retry_on(retry_on), .mon_route(mon_route));
   spi_master_model m (.ref_clk(ref_clk), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .pins(spi_pins));
   // 40 MHz clock
   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Hang guard, nearly four times the expected run
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         error_cnt++;
         $display("wrong value at %0t: timeout", $time);
         test_done;
      end
   end
   // ------------------------------------
   // Helpers
   // ------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic chk24(input logic [23:0] got, input logic [23:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------
   // Scenarios
   // ------------------------------------
   task automatic t_monitor;
      chk1(active_mode, 1'b0, "standby after reset");
      for (int i = 0; i < 4; i++)
      begin
         ctl = 24'h80_0000 | (24'(i) << 18);
         m.xfer(ctl, 24, rd);
         chk24(rd, (i == 1 || i == 2) ? 24'h84_0000 : 24'h80_0001, "status word");
         chk1(active_mode, 1'b1, "active after enable");
         chk24({20'h0_0000, mon_route}, {20'h0_0000, mon_exp[i]}, "monitor route");
      end
      chk1(outputs_allowed, 1'b1, "ready after start-up");
      $display("test monitor done");
   endtask
   // Each fault in turn, where only the thermal flag holds outputs off after the level drops; then bit 20 latches undervoltage
   task automatic t_faults;
      for (int i = 0; i < 4; i++)
      begin
         fault_in <= 4'h8 >> i;
         tick(20);
         chk1(outputs_allowed, i == 3, "outputs during fault");
         fault_in <= 4'h0;
         tick(20);
         chk1(outputs_allowed, i != 2, "outputs after fault");
         m.xfer(ctl, 24, rd);
         chk24(rd, 24'h80_0000 | (24'h40_0000 >> i), "flag kept");
         m.xfer(ctl | 24'h40_0000, 24, rd);
         m.xfer(ctl, 24, rd);
         chk24(rd, 24'h80_0001, "flags cleared");
         chk1(outputs_allowed, 1'b1, "outputs back");
      end
      ctl = ctl | 24'h10_0000;
      m.xfer(ctl, 24, rd);
      fault_in <= 4'h4;
      tick(20);
      fault_in <= 4'h0;
      tick(20);
      chk1(outputs_allowed, 1'b0, "recovery held off");
      m.xfer(ctl | 24'h40_0000, 24, rd);
      chk1(outputs_allowed, 1'b1, "recovery after clear");
      $display("test faults done");
   endtask
   // On-time over two retry periods of 100 cycles: 12 and 25 per period
   task automatic t_retry;
      int on;
      retry_enable <= 1'b1;
      overcurrent <= 1'b1;
      for (int d = 0; d < 2; d++)
      begin
         m.xfer(ctl | (d ? 24'h20_0000 : 24'h00_0000), 24, rd);
         tick(100);
         on = 0;
         repeat (200) @(negedge ref_clk) on += retry_on;
         // Back onto the rising edge before driving again
         tick(1);
         chk24(24'(on), d ? 24'h00_0032 : 24'h00_0018, "retry on-time");
      end
      retry_enable <= 1'b0;
      overcurrent <= 1'b0;
      tick(2);
      $display("test retry done");
   endtask
   // Short, long and register-one frames are ignored, then a real standby
   task automatic t_bad;
      for (int k = 0; k < 3; k++)
      begin
         m.xfer({23'h00_0000, k == 2}, k == 0 ? 23 : (k == 1 ? 25 : 24), rd);
         chk1(active_mode, 1'b1, "bad frame ignored");
      end
      m.xfer(24'h00_0000, 24, rd);
      chk1(active_mode, 1'b0, "standby entered");
      chk1(outputs_allowed, 1'b0, "outputs off in standby");
      $display("test frames done");
   endtask
   initial
   begin
      tick(3);
      reset <= 1'b0;
      tick(6);
      t_monitor;
      t_faults;
      t_retry;
      t_bad;
      test_done;
   end
endmodule
